/* File: design/single_cycle_8x8_multiplier.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mult_cfg.svh"
module single_cycle_8x8_multiplier
	import mult_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// instruction sequencer
	input wire logic i_multiply_with_working_register,
	input wire logic [`OPND_W-1:0] i_working_register,
	input wire logic [`OPND_W-1:0] i_file_register,
	// software writes to the product bytes
	input wire logic i_wr_product_high,
	input wire logic i_wr_product_low,
	input wire logic [`OPND_W-1:0] i_wr_data,
	// alu status passing through the multiplier
	input wire logic [`STAT_W-1:0] i_alu_status_register,
	// results
	output logic [`OPND_W-1:0] o_product_high_byte,
	output logic [`OPND_W-1:0] o_product_low_byte,
	output logic [`STAT_W-1:0] o_alu_status_register,
	output logic o_product_valid
);
	logic [`PROD_W-1:0] product_now;
	logic [`PROD_W-1:0] ref_product;
	logic [`OPND_W-1:0] product_high_byte;
	logic [`OPND_W-1:0] product_low_byte;
	logic [`OPND_W-1:0] next_high;
	logic [`OPND_W-1:0] next_low;
	logic [`STAT_W-1:0] alu_status;
	logic valid;
	logic take_multiply;
	logic take_write_high;
	logic take_write_low;
	prod_op_t op;

	// turns one cycle of requests into the operation the product bytes see
	function automatic prod_op_t decode_op(
		input logic mul,
		input logic wr_high,
		input logic wr_low
	);
		prod_op_t sel;
		sel = op_idle;
		if (mul) begin
			sel = op_multiply;
		end else if (wr_high) begin
			sel = op_write_high;
		end else if (wr_low) begin
			sel = op_write_low;
		end
		return sel;
	endfunction

	// combinational product of working register and file register
	unsigned_multiplier_array u_array (
		.i_a(i_working_register),
		.i_b(i_file_register),
		.o_product(product_now)
	);

	// multiply wins over a write; of two writes only the high one is taken
	assign op = decode_op(i_multiply_with_working_register, i_wr_product_high,
		i_wr_product_low);
	assign take_multiply = (op == op_multiply);
	assign take_write_high = (op == op_write_high);
	assign take_write_low = (op == op_write_low);

	// byte selection; unaffected bytes hold their value
	assign next_high = take_multiply ? product_now[`PROD_W-1:`OPND_W] :
		take_write_high ? i_wr_data : product_high_byte;
	assign next_low = take_multiply ? product_now[`OPND_W-1:0] :
		take_write_low ? i_wr_data : product_low_byte;

	// high product byte, loaded at the edge that takes the request
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			product_high_byte <= `BYTE_ZERO;
		end else begin
			product_high_byte <= next_high;
		end
	end

	// low product byte
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			product_low_byte <= `BYTE_ZERO;
		end else begin
			product_low_byte <= next_low;
		end
	end

	// one-cycle pulse marking a fresh product
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			valid <= 1'b0;
		end else begin
			valid <= take_multiply;
		end
	end

	// status passes through untouched by the multiply
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			alu_status <= `STAT_ZERO;
		end else begin
			alu_status <= i_alu_status_register;
		end
	end

	assign o_product_high_byte = product_high_byte;
	assign o_product_low_byte = product_low_byte;
	assign o_alu_status_register = alu_status;
	assign o_product_valid = valid;

	// reference product for the checks, kept apart from the array
	assign ref_product = `PROD_W'(i_working_register) * `PROD_W'(i_file_register);

	// checks on the multiply result
	a_full_product: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_multiply_with_working_register |=> {o_product_high_byte, o_product_low_byte} ==
			($past(i_working_register) * $past(i_file_register)))
		else $error("product mismatch");
	a_one_cycle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_multiply_with_working_register |=> o_product_valid)
		else $error("product not ready next cycle");
	a_high_byte: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_multiply_with_working_register |=> o_product_high_byte ==
			$past(ref_product[`PROD_W-1:`OPND_W]))
		else $error("high byte wrong");
	a_low_byte: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_multiply_with_working_register |=> o_product_low_byte ==
			$past(ref_product[`OPND_W-1:0]))
		else $error("low byte wrong");
	a_valid_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!i_multiply_with_working_register |=> !o_product_valid)
		else $error("valid without multiply");

	// checks on the status path
	a_flags_kept: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_multiply_with_working_register |=> o_alu_status_register == $past(i_alu_status_register))
		else $error("status changed by multiply");
	a_status_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!i_multiply_with_working_register |=>
			o_alu_status_register == $past(i_alu_status_register))
		else $error("status not passed through");

	// checks on operand source
	a_operand_source: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_multiply_with_working_register && i_file_register == 8'h01)
			|=> o_product_low_byte == $past(i_working_register))
		else $error("working register not used");

	// checks on holding, software writes and reset
	a_hold_value: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!i_multiply_with_working_register && !i_wr_product_high && !i_wr_product_low)
			|=> $stable(o_product_high_byte) && $stable(o_product_low_byte))
		else $error("product changed without cause");
	a_write_high: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!i_multiply_with_working_register && i_wr_product_high)
			|=> o_product_high_byte == $past(i_wr_data))
		else $error("high byte write lost");
	a_write_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!i_multiply_with_working_register && !i_wr_product_high && i_wr_product_low)
			|=> o_product_low_byte == $past(i_wr_data))
		else $error("low byte write lost");
	a_low_write_keeps: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!i_multiply_with_working_register && !i_wr_product_high && i_wr_product_low)
			|=> $stable(o_product_high_byte))
		else $error("high byte moved on low write");
	a_high_write_keeps: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!i_multiply_with_working_register && i_wr_product_high)
			|=> $stable(o_product_low_byte))
		else $error("low byte moved on high write");
	a_multiply_wins: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_multiply_with_working_register && (i_wr_product_high || i_wr_product_low))
			|=> {o_product_high_byte, o_product_low_byte} == $past(ref_product))
		else $error("write beat multiply");
	a_reset_clear: assert property (@(posedge i_clk)
		!i_rst_n |=> (o_product_high_byte == `BYTE_ZERO) && (o_product_low_byte == `BYTE_ZERO)
			&& (o_alu_status_register == `STAT_ZERO) && !o_product_valid)
		else $error("outputs not cleared by reset");

	// main scenarios
	c_multiply: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		i_multiply_with_working_register ##1 i_multiply_with_working_register);
	c_max_product: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		i_multiply_with_working_register && i_working_register == 8'hff && i_file_register == 8'hff);
	c_write_then_mul: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		i_wr_product_high ##1 i_multiply_with_working_register);
	c_both_writes: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		!i_multiply_with_working_register && i_wr_product_high && i_wr_product_low);
	c_write_low: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		!i_multiply_with_working_register && !i_wr_product_high && i_wr_product_low);
endmodule
`default_nettype wire

/* File: common/mult_cfg.svh */
`ifndef MULT_CFG_SVH
`define MULT_CFG_SVH
`define OPND_W 8
`define PROD_W 16
`define STAT_W 8
`define BYTE_ZERO 8'h00
`define STAT_ZERO 8'h00
`endif

/* File: common/mult_pkg.sv */
`include "mult_cfg.svh"
package mult_pkg;
	typedef logic [`OPND_W-1:0] byte_t;
	typedef logic [`PROD_W-1:0] prod_t;
	typedef enum logic [1:0] {
		op_idle,
		op_multiply,
		op_write_high,
		op_write_low
	} prod_op_t;
endpackage

/* File: design/unsigned_multiplier_array.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mult_cfg.svh"
// combinational unsigned 8 x 8 array multiplier built from shifted partial products
module unsigned_multiplier_array
	import mult_pkg::*;
(
	// operands
	input wire logic [`OPND_W-1:0] i_a,
	input wire logic [`OPND_W-1:0] i_b,
	// result
	output logic [`PROD_W-1:0] o_product
);
	logic [`PROD_W-1:0] partial [`OPND_W];
	logic [`PROD_W-1:0] sum [`OPND_W+1];

	assign sum[0] = '0;
	// one gated, shifted row per bit of the second operand, no sign extension
	genvar g;
	generate
		for (g = 0; g < `OPND_W; g++) begin : g_row
			assign partial[g] = i_b[g] ? ({{`OPND_W{1'b0}}, i_a} << g) : '0;
			assign sum[g+1] = sum[g] + partial[g];
		end
	endgenerate
	assign o_product = sum[`OPND_W];
endmodule
`default_nettype wire

/* File: tb/seq_signed_fixup.sv */
`timescale 1ns/1ps
`default_nettype none
// sequencer step turning the unsigned high byte into the signed one
module seq_signed_fixup
	import mult_pkg::*;
(
	// operands and unsigned high byte of one multiply
	input wire byte_t i_a,
	input wire byte_t i_b,
	input wire byte_t i_high,
	// wide operands and their four partial products
	input wire logic [15:0] i_wide_a,
	input wire logic [15:0] i_wide_b,
	input wire prod_t i_pp_ll,
	input wire prod_t i_pp_hh,
	input wire prod_t i_pp_lh,
	input wire prod_t i_pp_hl,
	// signed high byte and wide results
	output byte_t o_signed_high,
	output logic [31:0] o_wide_unsigned,
	output logic [31:0] o_wide_signed
);
	// take off the other operand for each negative one
	assign o_signed_high = i_high - (i_b[7] ? i_a : 8'h00) - (i_a[7] ? i_b : 8'h00);
	// weight the four partial products and add them
	assign o_wide_unsigned = {i_pp_hh, 16'h0000} + {8'h00, i_pp_lh, 8'h00}
		+ {8'h00, i_pp_hl, 8'h00} + {16'h0000, i_pp_ll};
	// take the other wide operand off the upper half for each negative one
	assign o_wide_signed = o_wide_unsigned
		- {(i_wide_b[15] ? i_wide_a : 16'h0000), 16'h0000}
		- {(i_wide_a[15] ? i_wide_b : 16'h0000), 16'h0000};
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
	import mult_pkg::*;
;
	logic clk, rst_n, mul, wh, wl, vld;
	byte_t a, b, d, st, hi, lo, sto, na, nb, sh, eh, el;
	logic [40:0] q[$];
	logic [40:0] n;
	int failures, comparisons, cyc, cycles, seed, r, s, p, k;
	logic [15:0] wa, wb;
	prod_t pp_ll, pp_hh, pp_lh, pp_hl;
	logic [31:0] wide_u, wide_s;
	single_cycle_8x8_multiplier single_cycle_8x8_multiplier_inst (.i_clk(clk), .i_rst_n(rst_n),
		.i_multiply_with_working_register(mul), .i_working_register(a), .i_file_register(b),
		.i_wr_product_high(wh), .i_wr_product_low(wl), .i_wr_data(d),
		.i_alu_status_register(st), .o_product_high_byte(hi), .o_product_low_byte(lo),
		.o_alu_status_register(sto), .o_product_valid(vld));
	seq_signed_fixup seq_signed_fixup_inst (.i_a(na), .i_b(nb), .i_high(hi),
		.i_wide_a(wa), .i_wide_b(wb), .i_pp_ll(pp_ll), .i_pp_hh(pp_hh), .i_pp_lh(pp_lh),
		.i_pp_hl(pp_hl), .o_signed_high(sh), .o_wide_unsigned(wide_u), .o_wide_signed(wide_s));
	// 50 ns clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// apply one cycle of inputs and note what the outputs must show after it
	task automatic drive(input logic rn, input logic [2:0] ctl, input byte_t av,
		input byte_t bv, input byte_t dv, input byte_t sv);
		@(posedge clk);
		#1;
		rst_n = rn;
		{mul, wh, wl} = ctl;
		{a, b, d, st} = {av, bv, dv, sv};
		if (!rst_n) {eh, el} = 16'h0000;
		else if (mul) {eh, el} = a * b;
		else if (wh) eh = d;
		else if (wl) el = d;
		q.push_back({rst_n & mul, rst_n ? st : 8'h00, eh, el, a, b});
	endtask
	// random ops with a mid-run reset, then directed and wide sequences
	initial begin
		seed = 14496;
		{rst_n, mul, wh, wl, a, b, d, st, eh, el} = '0;
		for (cyc = 0; cyc < 600; cyc++) begin
			r = $random(seed);
			s = $random(seed);
			if (cyc < 12) s[31:16] = 16'hffff;
			drive((cyc >= 8) && (cyc != 300), r[2:0], s[31:24], s[23:16], s[15:8], s[7:0]);
		end
		drive(1'b1, 3'b100, 8'h5a, 8'h01, 8'h00, 8'h00);
		for (k = 0; k < 4; k++) begin
			r = $random(seed);
			{wa, wb} = r;
			wa[15] = k[0];
			wb[15] = k[1];
			drive(1'b1, 3'b100, wa[7:0], wb[7:0], 8'h00, 8'h00);
			drive(1'b1, 3'b100, wa[15:8], wb[15:8], 8'h00, 8'h00);
			pp_ll = {hi, lo};
			drive(1'b1, 3'b100, wa[7:0], wb[15:8], 8'h00, 8'h00);
			pp_hh = {hi, lo};
			drive(1'b1, 3'b100, wa[15:8], wb[7:0], 8'h00, 8'h00);
			pp_lh = {hi, lo};
			drive(1'b1, 3'b000, 8'h00, 8'h00, 8'h00, 8'h00);
			pp_hl = {hi, lo};
			#1;
			check("wide unsigned", wa * wb, wide_u);
			check("wide signed", $signed(wa) * $signed(wb), wide_s);
		end
		repeat (2) @(posedge clk);
		report_and_stop();
	end
	// compare outputs against the oldest note
	always @(posedge clk) begin
		#0.5;
		if (q.size() > 0) begin
			n = q.pop_front();
			{na, nb} = n[15:0];
			p = $signed(na) * $signed(nb);
			#0.1;
			check("product", n[31:16], {hi, lo});
			check("valid", {15'h0000, n[40]}, {15'h0000, vld});
			check("status", {8'h00, n[39:32]}, {8'h00, sto});
			if (n[40]) check("signed high", {8'h00, p[15:8]}, {8'h00, sh});
		end
	end
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 1000) begin
			failures++;
			report_and_stop();
		end
	end
endmodule
`default_nettype wire
